// File: src/ulp_lp_divisor.sv
// Low-power divisor latch with AXI4-Lite slave and SIR minimum-pulse detector.
// Assumes the AXI master and sir_rx_in; sir_rx_in is a pin and is synchronised here.
//
// The AXI4-Lite interface to the registers was chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
module ulp_lp_divisor (
   input wire logic core_clk, // Serial clock, 100 MHz
   input wire logic sys_rst, // Synchronous reset, high
   input wire logic [31:0] s_axi_awaddr, // Write address
   input wire logic s_axi_awvalid, // Write address valid
   output logic s_axi_awready, // Write address ready
   input wire logic [31:0] s_axi_wdata, // Write data
   input wire logic [3:0] s_axi_wstrb, // Write byte strobes
   input wire logic s_axi_wvalid, // Write data valid
   output logic s_axi_wready, // Write data ready
   output logic [1:0] s_axi_bresp, // Write response
   output logic s_axi_bvalid, // Write response valid
   input wire logic s_axi_bready, // Write response ready
   input wire logic [31:0] s_axi_araddr, // Read address
   input wire logic s_axi_arvalid, // Read address valid
   output logic s_axi_arready, // Read address ready
   output logic [31:0] s_axi_rdata, // Read data
   output logic [1:0] s_axi_rresp, // Read response
   output logic s_axi_rvalid, // Read data valid
   input wire logic s_axi_rready, // Read data ready
   input wire logic sir_rx_in, // SIR receive pin, pulse active high
   output logic lp_baud_tick, // One-cycle low-power baud tick
   output logic lp_pulse_det // One-cycle valid-pulse indication
);
   ulp_div_if div ();

   typedef enum logic [1:0] {
      ULP_W_IDLE = 2'b00,
      ULP_W_RESP = 2'b01
   } ulp_wstate_e;

   function automatic logic [1:0] ulp_decode(input logic [31:0] a);
      // 0 lo, 1 hi, 2 ctrl, 3 stat; unmapped flagged separately
      case (a)
         ulp_pkg::ULP_ADDR_DIV_LO: ulp_decode = 2'd0;
         ulp_pkg::ULP_ADDR_DIV_HI: ulp_decode = 2'd1;
         ulp_pkg::ULP_ADDR_CTRL: ulp_decode = 2'd2;
         default: ulp_decode = 2'd3;
      endcase
   endfunction

   function automatic logic ulp_mapped(input logic [31:0] a);
      ulp_mapped = (a == ulp_pkg::ULP_ADDR_DIV_LO) || (a == ulp_pkg::ULP_ADDR_DIV_HI)
         || (a == ulp_pkg::ULP_ADDR_CTRL) || (a == ulp_pkg::ULP_ADDR_STAT);
   endfunction

   logic [7:0] div_lo_r, div_lo_nxt;
   logic [7:0] div_hi_r, div_hi_nxt;
   logic [1:0] ctrl_r, ctrl_nxt;
   logic reload_r, reload_nxt;
   ulp_wstate_e ws_r, ws_nxt;
   logic aw_got_r, aw_got_nxt;
   logic w_got_r, w_got_nxt;
   logic [31:0] awaddr_r, awaddr_nxt;
   logic [31:0] wdata_r, wdata_nxt;
   logic wstrb0_r, wstrb0_nxt;
   logic [1:0] bresp_r, bresp_nxt;
   logic rvalid_r, rvalid_nxt;
   logic [31:0] rdata_r, rdata_nxt;
   logic [1:0] rresp_r, rresp_nxt;
   logic [1:0] rx_sync_r;
   logic [3:0] hi_cnt_r, hi_cnt_nxt;
   logic det_r, det_nxt;
   logic armed_r, armed_nxt;
   logic [31:0] wa;
   logic div_access, div_reg_w;

   assign div_access = ctrl_r[ulp_pkg::ULP_CTRL_ACCESS_BIT];
   assign div.divisor = {div_hi_r, div_lo_r};
   assign div.reload = reload_r;

   // Write channel
   assign s_axi_awready = (ws_r == ULP_W_IDLE) && !aw_got_r;
   assign s_axi_wready = (ws_r == ULP_W_IDLE) && !w_got_r;
   assign s_axi_bvalid = (ws_r == ULP_W_RESP);
   assign s_axi_bresp = bresp_r;

   always_comb begin
      ws_nxt = ws_r;
      aw_got_nxt = aw_got_r;
      w_got_nxt = w_got_r;
      awaddr_nxt = awaddr_r;
      wdata_nxt = wdata_r;
      wstrb0_nxt = wstrb0_r;
      bresp_nxt = bresp_r;
      div_lo_nxt = div_lo_r;
      div_hi_nxt = div_hi_r;
      ctrl_nxt = ctrl_r;
      reload_nxt = 1'b0;
      wa = awaddr_r;
      div_reg_w = 1'b0;
      case (ws_r)
         ULP_W_IDLE: begin
            if (s_axi_awvalid && !aw_got_r) begin
               aw_got_nxt = 1'b1;
               awaddr_nxt = s_axi_awaddr;
            end
            if (s_axi_wvalid && !w_got_r) begin
               w_got_nxt = 1'b1;
               wdata_nxt = s_axi_wdata;
               wstrb0_nxt = s_axi_wstrb[0];
            end
            if (aw_got_r && w_got_r) begin
               aw_got_nxt = 1'b0;
               w_got_nxt = 1'b0;
               ws_nxt = ULP_W_RESP;
               bresp_nxt = ulp_pkg::ULP_RESP_OKAY;
               div_reg_w = (ulp_decode(wa) < 2'd2);
               if (!ulp_mapped(wa)) begin
                  bresp_nxt = ulp_pkg::ULP_RESP_DECERR;
               end else if (div_reg_w && !div_access) begin
                  bresp_nxt = ulp_pkg::ULP_RESP_SLVERR;
               end else if (wstrb0_r) begin
                  case (ulp_decode(wa))
                     2'd0: begin
                        div_lo_nxt = wdata_r[7:0];
                        reload_nxt = 1'b1;
                     end
                     2'd1: begin
                        div_hi_nxt = wdata_r[7:0];
                        reload_nxt = 1'b1;
                     end
                     2'd2: ctrl_nxt = wdata_r[1:0];
                     default: ctrl_nxt = ctrl_r;
                  endcase
               end
            end
         end
         ULP_W_RESP: begin
            if (s_axi_bready) begin
               ws_nxt = ULP_W_IDLE;
            end
         end
         default: ws_nxt = ULP_W_IDLE;
      endcase
   end

   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         ws_r <= ULP_W_IDLE;
         aw_got_r <= 1'b0;
         w_got_r <= 1'b0;
         awaddr_r <= 32'h00000000;
         wdata_r <= 32'h00000000;
         wstrb0_r <= 1'b0;
         bresp_r <= ulp_pkg::ULP_RESP_OKAY;
         div_lo_r <= ulp_pkg::ULP_DIV_RESET;
         div_hi_r <= ulp_pkg::ULP_DIV_RESET;
         ctrl_r <= ulp_pkg::ULP_CTRL_RESET;
         reload_r <= 1'b0;
      end else begin
         ws_r <= ws_nxt;
         aw_got_r <= aw_got_nxt;
         w_got_r <= w_got_nxt;
         awaddr_r <= awaddr_nxt;
         wdata_r <= wdata_nxt;
         wstrb0_r <= wstrb0_nxt;
         bresp_r <= bresp_nxt;
         div_lo_r <= div_lo_nxt;
         div_hi_r <= div_hi_nxt;
         ctrl_r <= ctrl_nxt;
         reload_r <= reload_nxt;
      end
   end

   // Read channel
   assign s_axi_arready = !rvalid_r;
   assign s_axi_rvalid = rvalid_r;
   assign s_axi_rdata = rdata_r;
   assign s_axi_rresp = rresp_r;

   always_comb begin
      rvalid_nxt = rvalid_r;
      rdata_nxt = rdata_r;
      rresp_nxt = rresp_r;
      if (rvalid_r && s_axi_rready) begin
         rvalid_nxt = 1'b0;
      end else if (!rvalid_r && s_axi_arvalid) begin
         rvalid_nxt = 1'b1;
         rdata_nxt = 32'h00000000;
         rresp_nxt = ulp_pkg::ULP_RESP_OKAY;
         if (!ulp_mapped(s_axi_araddr)) begin
            rresp_nxt = ulp_pkg::ULP_RESP_DECERR;
         end else if (s_axi_araddr == ulp_pkg::ULP_ADDR_STAT) begin
            rdata_nxt = {29'h0, armed_r, div.tick16, (div.divisor != 16'h0000)};
         end else if (ulp_decode(s_axi_araddr) == 2'd2) begin
            rdata_nxt = {30'h0, ctrl_r};
         end else if (!div_access) begin
            rresp_nxt = ulp_pkg::ULP_RESP_SLVERR;
         end else if (ulp_decode(s_axi_araddr) == 2'd0) begin
            rdata_nxt = {24'h000000, div_lo_r};
         end else begin
            rdata_nxt = {24'h000000, div_hi_r};
         end
      end
   end

   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         rvalid_r <= 1'b0;
         rdata_r <= 32'h00000000;
         rresp_r <= ulp_pkg::ULP_RESP_OKAY;
      end else begin
         rvalid_r <= rvalid_nxt;
         rdata_r <= rdata_nxt;
         rresp_r <= rresp_nxt;
      end
   end

   ulp_baud_gen u_gen (
      .core_clk(core_clk),
      .sys_rst(sys_rst),
      .div(div.gen)
   );

   // Minimum pulse width detector on sixteen-times ticks
   always_comb begin
      hi_cnt_nxt = hi_cnt_r;
      det_nxt = 1'b0;
      armed_nxt = armed_r;
      if (div.divisor == 16'h0000 || !ctrl_r[ulp_pkg::ULP_CTRL_LPMODE_BIT]) begin
         hi_cnt_nxt = 4'h0;
         armed_nxt = 1'b0;
      end else if (!rx_sync_r[1]) begin
         hi_cnt_nxt = 4'h0;
         det_nxt = armed_r;
         armed_nxt = 1'b0;
      end else if (div.tick16 && hi_cnt_r != 4'hF) begin
         hi_cnt_nxt = hi_cnt_r + 4'h1;
         armed_nxt = armed_r || (hi_cnt_r + 4'h1 >= ulp_pkg::ULP_MIN_PULSE_TICKS);
      end
   end

   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         rx_sync_r <= 2'h0;
         hi_cnt_r <= 4'h0;
         det_r <= 1'b0;
         armed_r <= 1'b0;
      end else begin
         rx_sync_r <= {rx_sync_r[0], sir_rx_in};
         hi_cnt_r <= hi_cnt_nxt;
         det_r <= det_nxt;
         armed_r <= armed_nxt;
      end
   end

   assign lp_baud_tick = div.baud_tick;
   assign lp_pulse_det = det_r;

   // Register access checks
   chk_access_gate: assert property (@(posedge core_clk) disable iff (sys_rst)
      (!div_access && ws_r == ULP_W_IDLE && aw_got_r && w_got_r) |=> $stable(div.divisor))
      else $error("divisor changed without access bit");
   chk_write_gate: assert property (@(posedge core_clk) disable iff (sys_rst)
      (!div_access && ws_r == ULP_W_IDLE && aw_got_r && w_got_r && ulp_decode(awaddr_r) < 2'd2)
      |=> s_axi_bvalid && s_axi_bresp == ulp_pkg::ULP_RESP_SLVERR)
      else $error("divisor write without access bit not refused");
   chk_lo_write_lands: assert property (@(posedge core_clk) disable iff (sys_rst)
      (div_access && ws_r == ULP_W_IDLE && aw_got_r && w_got_r && wstrb0_r && awaddr_r == ulp_pkg::ULP_ADDR_DIV_LO)
      |=> div_lo_r == $past(wdata_r[7:0]) && reload_r)
      else $error("low divisor write lost");
   chk_hi_write_lands: assert property (@(posedge core_clk) disable iff (sys_rst)
      (div_access && ws_r == ULP_W_IDLE && aw_got_r && w_got_r && wstrb0_r && awaddr_r == ulp_pkg::ULP_ADDR_DIV_HI)
      |=> div_hi_r == $past(wdata_r[7:0]) && reload_r)
      else $error("high divisor write lost");
   chk_lo_read_value: assert property (@(posedge core_clk) disable iff (sys_rst)
      (!rvalid_r && s_axi_arvalid && div_access && s_axi_araddr == ulp_pkg::ULP_ADDR_DIV_LO)
      |=> rdata_r == {24'h000000, $past(div_lo_r)})
      else $error("low divisor read value wrong");
   chk_hi_read_value: assert property (@(posedge core_clk) disable iff (sys_rst)
      (!rvalid_r && s_axi_arvalid && div_access && s_axi_araddr == ulp_pkg::ULP_ADDR_DIV_HI)
      |=> rdata_r == {24'h000000, $past(div_hi_r)})
      else $error("high divisor read value wrong");
   chk_read_gate: assert property (@(posedge core_clk) disable iff (sys_rst)
      (!rvalid_r && s_axi_arvalid && !div_access && ulp_decode(s_axi_araddr) < 2'd2)
      |=> rresp_r == ulp_pkg::ULP_RESP_SLVERR && rdata_r == 32'h00000000)
      else $error("divisor read without access bit not refused");
   chk_read_upper_zero: assert property (@(posedge core_clk) disable iff (sys_rst)
      rvalid_r |-> rdata_r[31:8] == 24'h000000)
      else $error("reserved read bits set");
   chk_reset_zero: assert property (@(posedge core_clk) sys_rst |=> div.divisor == 16'h0000)
      else $error("divisor not zero after reset");

   // Pulse detector checks
   chk_zero_no_detect: assert property (@(posedge core_clk) disable iff (sys_rst)
      (div.divisor == 16'h0000) ##1 (div.divisor == 16'h0000) |-> !det_r)
      else $error("pulse detected with zero divisor");
   chk_zero_disarm: assert property (@(posedge core_clk) disable iff (sys_rst)
      (div.divisor == 16'h0000) |=> !armed_r && hi_cnt_r == 4'h0)
      else $error("detector armed with zero divisor");
   chk_detect_width: assert property (@(posedge core_clk) disable iff (sys_rst)
      det_r |-> $past(hi_cnt_r) >= ulp_pkg::ULP_MIN_PULSE_TICKS)
      else $error("pulse flagged below minimum width");
endmodule
`default_nettype wire

// File: src/ulp_pkg.sv
// Constants of the low-power divisor latch block.
// Assumes a 100 MHz core_clk and an AXI4-Lite master with 32-bit data.
package ulp_pkg;
   localparam logic [31:0] ULP_ADDR_DIV_LO = 32'h50001020;
   localparam logic [31:0] ULP_ADDR_DIV_HI = 32'h50001024;
   localparam logic [31:0] ULP_ADDR_CTRL = 32'h50001040;
   localparam logic [31:0] ULP_ADDR_STAT = 32'h50001044;
   localparam int ULP_CTRL_ACCESS_BIT = 0;
   localparam int ULP_CTRL_LPMODE_BIT = 1;
   localparam logic [7:0] ULP_DIV_RESET = 8'h00;
   localparam logic [1:0] ULP_CTRL_RESET = 2'h0;
   localparam logic [3:0] ULP_OVERSAMPLE_LAST = 4'hF;
   localparam logic [3:0] ULP_MIN_PULSE_TICKS = 4'h3;
   localparam logic [1:0] ULP_RESP_OKAY = 2'h0;
   localparam logic [1:0] ULP_RESP_SLVERR = 2'h2;
   localparam logic [1:0] ULP_RESP_DECERR = 2'h3;
endpackage

// File: src/ulp_div_if.sv
// Interface between the register slave and the baud generator.
// Assumes both ends run on the same core clock.
`timescale 1ns/1ps
`default_nettype none
interface ulp_div_if;
   logic [15:0] divisor;
   logic reload;
   logic tick16;
   logic baud_tick;
   modport regs (output divisor, output reload, input tick16, input baud_tick);
   modport gen (input divisor, input reload, output tick16, output baud_tick);
endinterface
`default_nettype wire

// File: src/ulp_baud_gen.sv
// Low-power baud generator: sixteen-times tick and baud tick from a divisor.
// Assumes divisor and reload come from logic on core_clk.
`timescale 1ns/1ps
`default_nettype none
module ulp_baud_gen (
   input wire logic core_clk, // Serial clock
   input wire logic sys_rst, // Synchronous reset, high
   ulp_div_if.gen div // Divisor in, ticks out
);
   logic [15:0] cnt_r, cnt_nxt;
   logic [3:0] os_r, os_nxt;
   logic t16_r, t16_nxt;
   logic bt_r, bt_nxt;

   always_comb begin
      cnt_nxt = cnt_r;
      os_nxt = os_r;
      t16_nxt = 1'b0;
      bt_nxt = 1'b0;
      if (div.reload || div.divisor == 16'h0000) begin
         cnt_nxt = 16'h0001;
         os_nxt = 4'h0;
      end else if (cnt_r >= div.divisor) begin
         cnt_nxt = 16'h0001;
         t16_nxt = 1'b1;
         os_nxt = os_r + 4'h1;
         bt_nxt = (os_r == ulp_pkg::ULP_OVERSAMPLE_LAST);
      end else begin
         cnt_nxt = cnt_r + 16'h0001;
      end
   end

   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         cnt_r <= 16'h0001;
         os_r <= 4'h0;
         t16_r <= 1'b0;
         bt_r <= 1'b0;
      end else begin
         cnt_r <= cnt_nxt;
         os_r <= os_nxt;
         t16_r <= t16_nxt;
         bt_r <= bt_nxt;
      end
   end

   assign div.tick16 = t16_r;
   assign div.baud_tick = bt_r;

   chk_zero_no_tick: assert property (@(posedge core_clk) disable iff (sys_rst)
      ($past(div.divisor) == 16'h0000) |-> !t16_r)
      else $error("tick with zero divisor");
   chk_tick_spacing: assert property (@(posedge core_clk) disable iff (sys_rst)
      (t16_r && div.divisor == 16'h0002 && !div.reload) ##1 (div.divisor == 16'h0002 && !div.reload)
      |-> !t16_r ##1 t16_r)
      else $error("tick spacing differs from divisor");
   chk_reload_clear: assert property (@(posedge core_clk) disable iff (sys_rst)
      div.reload |=> !t16_r)
      else $error("tick right after reload");
endmodule
`default_nettype wire

// File: testbench/ulp_sir_xcvr.sv
// Model of the infrared transceiver driving the SIR receive pin.
// Assumes the bench asks for one pulse at a time with a one-cycle fire strobe.
`timescale 1ns/1ps
`default_nettype none
module ulp_sir_xcvr (
   input wire logic core_clk, // Serial clock
   input wire logic fire, // One-cycle pulse request
   input wire logic [15:0] width, // Pulse length in clocks
   output logic sir_rx_in // Receive pin, high during a pulse
);
   logic [15:0] left_r = 16'h0000;
   always @(posedge core_clk) begin
      if (fire) begin
         left_r <= width;
      end else if (left_r != 16'h0000) begin
         left_r <= left_r - 16'h0001;
      end
   end
   // Line rests low between pulses, as the optical receiver does
   assign sir_rx_in = (left_r != 16'h0000);
endmodule
`default_nettype wire

// File: testbench/tb_ulp_lp_divisor.sv
// Bench of the low-power divisor latch: register access, baud period, pulse detection.
// Assumes ulp_pkg, ulp_lp_divisor and the transceiver model ulp_sir_xcvr.
`timescale 1ns/1ps
`default_nettype none
module tb_ulp_lp_divisor;
   logic core_clk = 1'b0;
   logic sys_rst = 1'b1;
   logic [31:0] awaddr = 32'h0, wdata = 32'h0, araddr = 32'h0, rdata;
   logic awvalid = 1'b0, wvalid = 1'b0, arvalid = 1'b0, fire = 1'b0;
   logic awready, wready, bvalid, arready, rvalid, tick, det, rx;
   logic [1:0] bresp, rresp;
   logic [15:0] width = 16'h0;
   logic [31:0] amap [4] = '{ulp_pkg::ULP_ADDR_DIV_LO, ulp_pkg::ULP_ADDR_DIV_HI,
                             ulp_pkg::ULP_ADDR_CTRL, 32'h50001028};
   int n_mismatch = 0, cmp_count = 0, cyc = 0, last = 0, gap = 0, n_tick = 0, n_det = 0;
   int m_lo = 0, m_hi = 0, m_ctrl = 0, lo, hi, n;
   // Nearest divisor giving 115.2K baud from a 100 MHz serial clock
   localparam int SIR_DIV = (100000000 + 8 * 115200) / (16 * 115200);
   always #5 core_clk = ~core_clk;
   ulp_lp_divisor u_dut (.core_clk(core_clk), .sys_rst(sys_rst), .s_axi_awaddr(awaddr),
      .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hF),
      .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
      .s_axi_bready(1'b1), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
      .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(1'b1),
      .sir_rx_in(rx), .lp_baud_tick(tick), .lp_pulse_det(det));
   ulp_sir_xcvr u_sir (.core_clk(core_clk), .fire(fire), .width(width), .sir_rx_in(rx));
   task automatic report_and_stop();
      $display("comparisons %0d mismatches %0d", cmp_count, n_mismatch);
      if (n_mismatch == 0 && cmp_count > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask
   always @(posedge core_clk) begin
      cyc <= cyc + 1;
      if (tick === 1'b1) begin
         gap <= cyc - last;
         last <= cyc;
         n_tick <= n_tick + 1;
      end
      if (det === 1'b1) n_det <= n_det + 1;
      if (cyc == 40000) begin
         n_mismatch = n_mismatch + 1;
         report_and_stop();
      end
   end
   task automatic chk_word(input string nm, input logic [31:0] e, input logic [31:0] g);
      cmp_count++;
      if (g !== e) begin
         n_mismatch++;
         $display("MISMATCH %s expected %h seen %h", nm, e, g);
      end
   endtask
   task automatic chk_resp(input string nm, input logic [1:0] e, input logic [1:0] g);
      cmp_count++;
      if (g !== e) begin
         n_mismatch++;
         $display("MISMATCH %s expected %h seen %h", nm, e, g);
      end
   endtask
   function automatic logic [1:0] exp_resp(input logic [31:0] a);
      if (a == ulp_pkg::ULP_ADDR_DIV_LO || a == ulp_pkg::ULP_ADDR_DIV_HI) begin
         return m_ctrl[ulp_pkg::ULP_CTRL_ACCESS_BIT] ? ulp_pkg::ULP_RESP_OKAY : ulp_pkg::ULP_RESP_SLVERR;
      end
      return (a == ulp_pkg::ULP_ADDR_CTRL || a == ulp_pkg::ULP_ADDR_STAT) ?
         ulp_pkg::ULP_RESP_OKAY : ulp_pkg::ULP_RESP_DECERR;
   endfunction
   // Address and data offered together, each released once taken; bready stays high
   task automatic wr(input logic [31:0] a, input logic [31:0] d);
      logic pa, pw, ta, tw, tb;
      logic [1:0] r;
      pa = 1'b1;
      pw = 1'b1;
      awaddr <= a;
      wdata <= d;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      do begin
         @(negedge core_clk);
         ta = pa && awready;
         tw = pw && wready;
         @(posedge core_clk);
         if (ta) pa = 1'b0;
         if (tw) pw = 1'b0;
         if (ta) awvalid <= 1'b0;
         if (tw) wvalid <= 1'b0;
      end while (pa || pw);
      do begin
         @(negedge core_clk);
         tb = bvalid;
         r = bresp;
         @(posedge core_clk);
      end while (tb !== 1'b1);
      chk_resp("bresp", exp_resp(a), r);
      if (exp_resp(a) == ulp_pkg::ULP_RESP_OKAY) begin
         if (a == ulp_pkg::ULP_ADDR_DIV_LO) m_lo = d & 32'hFF;
         else if (a == ulp_pkg::ULP_ADDR_DIV_HI) m_hi = d & 32'hFF;
         else if (a == ulp_pkg::ULP_ADDR_CTRL) m_ctrl = d & 32'h3;
      end
   endtask
   task automatic rd(input logic [31:0] a);
      logic tr;
      logic [1:0] r;
      logic [31:0] d;
      int e;
      araddr <= a;
      arvalid <= 1'b1;
      do begin
         @(negedge core_clk);
         tr = arready;
         @(posedge core_clk);
      end while (tr !== 1'b1);
      arvalid <= 1'b0;
      do begin
         @(negedge core_clk);
         tr = rvalid;
         r = rresp;
         d = rdata;
         @(posedge core_clk);
      end while (tr !== 1'b1);
      e = (exp_resp(a) != ulp_pkg::ULP_RESP_OKAY) ? 0 : (a == ulp_pkg::ULP_ADDR_DIV_LO) ? m_lo :
          (a == ulp_pkg::ULP_ADDR_DIV_HI) ? m_hi :
          (a == ulp_pkg::ULP_ADDR_STAT) ? int'((m_lo | m_hi) != 0) : m_ctrl;
      // Status is read only while no tick and no armed pulse can be pending
      chk_resp("rresp", exp_resp(a), r);
      chk_word("rdata", 32'(e), d);
   endtask
   task automatic pulse(input int w, input int e);
      int k;
      k = n_det;
      width <= 16'(w);
      fire <= 1'b1;
      @(posedge core_clk);
      fire <= 1'b0;
      repeat (w + 60) @(posedge core_clk);
      chk_word("pulse_det", 32'(e), 32'(n_det - k));
   endtask
   initial begin
      void'($urandom(49));
      repeat (2) @(posedge core_clk);
      sys_rst <= 1'b0;
      @(posedge core_clk);
      rd(ulp_pkg::ULP_ADDR_DIV_LO);
      rd(ulp_pkg::ULP_ADDR_STAT);
      wr(ulp_pkg::ULP_ADDR_CTRL, 32'h1);
      rd(ulp_pkg::ULP_ADDR_DIV_LO);
      rd(ulp_pkg::ULP_ADDR_DIV_HI);
      repeat (20) begin
         n = $urandom % 4;
         if ($urandom % 2) wr(amap[n], $urandom);
         else rd(amap[n]);
      end
      wr(ulp_pkg::ULP_ADDR_CTRL, 32'h3);
      for (int k = 0; k < 3; k++) begin
         lo = (k == 0) ? 1 + $urandom % 4 : (k == 1) ? 0 : SIR_DIV;
         hi = (k == 1) ? 1 : 0;
         wr(ulp_pkg::ULP_ADDR_DIV_LO, 32'(lo));
         wr(ulp_pkg::ULP_ADDR_DIV_HI, 32'(hi));
         repeat (8) @(posedge core_clk);
         n = n_tick;
         repeat (9000) begin
            @(posedge core_clk);
            if (n_tick >= n + 2) break;
         end
         chk_word("baud_gap", 32'(16 * (hi * 256 + lo)), 32'(gap));
      end
      wr(ulp_pkg::ULP_ADDR_DIV_LO, 32'h2);
      wr(ulp_pkg::ULP_ADDR_DIV_HI, 32'h0);
      repeat (8) @(posedge core_clk);
      pulse(40, 1);
      pulse(2, 0);
      wr(ulp_pkg::ULP_ADDR_DIV_LO, 32'h0);
      repeat (8) @(posedge core_clk);
      n = n_tick;
      pulse(40, 0);
      repeat (300) @(posedge core_clk);
      chk_word("ticks_off", 32'h0, 32'(n_tick - n));
      rd(ulp_pkg::ULP_ADDR_STAT);
      report_and_stop();
   end
endmodule
`default_nettype wire
